//--- fau_pkg.sv
// package: constants, types and shared float helpers of the float unit
`default_nettype none
package fau_pkg;

   // register offsets (byte addresses on the APB)
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OPER = 8'h04;
   localparam logic [7:0] OFS_CONST1 = 8'h08;
   localparam logic [7:0] OFS_CONST2 = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_INT_STAT = 8'h14;
   localparam logic [7:0] OFS_INT_MASK = 8'h18;
   localparam logic [7:0] OFS_DATA_BASE = 8'h40;

   // control fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_PULSE_BIT = 2;
   localparam int CTRL_K1_BIT = 3;
   localparam int CTRL_K2_BIT = 4;
   localparam logic [1:0] OP_CONV = 2'h0;
   localparam logic [1:0] OP_ADD = 2'h1;
   localparam logic [1:0] OP_SUB = 2'h2;

   // operand index fields
   localparam int OPER_S1_LSB = 0;
   localparam int OPER_S2_LSB = 8;
   localparam int OPER_D_LSB = 16;

   // flag and interrupt bit layout (shared)
   localparam int FLG_DONE = 0;
   localparam int FLG_ZERO = 1;
   localparam int FLG_BORROW = 2;
   localparam int FLG_CARRY = 3;

   // reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] OPER_RESET = 32'h0000_0000;
   localparam logic [31:0] CONST_RESET = 32'h0000_0000;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // binary float constants
   localparam int BIAS = 127;
   localparam logic signed [11:0] EXP_FULL = 12'sh0FF;
   localparam logic [31:0] FLOAT_MAX = 32'h7F7F_FFFF;
   localparam logic [35:0] TEN = 36'h0_0000_000A;

   typedef enum logic [1:0] {ST_IDLE, ST_ADD, ST_CONV} fau_state_type;

   // leading zero count, 32 when the word is zero
   function automatic logic [5:0] fau_lzc(input logic [31:0] v);
      logic [5:0] n;
      n = 6'h20;
      for (int i = 0; i < 32; i++)
         if (v[i]) n = 6'(31 - i);
      return n;
   endfunction

   // {biased exponent, mantissa with hidden one at bit 31}; denormals read as zero
   function automatic logic [39:0] fau_unpack(input logic [31:0] f);
      if (f[30:23] == 8'h00)
         return 40'h00_0000_0000;
      return {f[30:23], 1'b1, f[22:0], 8'h00};
   endfunction

   // {carry, borrow, zero, word}; truncating, saturates high, flushes low
   function automatic logic [34:0] fau_pack(input logic s, input logic signed [11:0] e,
                                            input logic [31:0] m);
      if (m == 32'h0)
         return {3'h1, 32'h0};
      if (e >= EXP_FULL)
         return {3'h4, s, FLOAT_MAX[30:0]};
      if (e <= 12'sh000)
         return {3'h2, s, 31'h0};
      return {3'h0, s, e[7:0], m[30:8]};
   endfunction

   // signed integer constant to binary float, exact up to 24 bits
   function automatic logic [31:0] fau_int_to_float(input logic [31:0] k);
      logic [31:0] a;
      logic [31:0] m;
      logic [5:0] z;
      a = k[31] ? 32'(-k) : k;
      z = fau_lzc(a);
      m = a << z;
      if (a == 32'h0)
         return 32'h0;
      return {k[31], 8'(BIAS + 31 - int'(z)), m[30:8]};
   endfunction

endpackage
`default_nettype wire

//--- fau_addsub.sv
// combinational binary float adder and subtractor
`timescale 1ns/10ps
`default_nettype none
module fau_addsub
(
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic sub,
   output logic [34:0] result
);
   import fau_pkg::*;

   logic [39:0] ua, ub;
   logic sx, sy;
   logic [7:0] ex, d;
   logic [31:0] mx, my, ms;
   logic [32:0] sum;
   logic [5:0] z;
   logic signed [11:0] er;

   // align smaller operand, add or subtract magnitudes, renormalise, pack
   always_comb
   begin
      ua = fau_unpack(a);
      ub = fau_unpack(b);
      z = 6'h00;
      if (ua >= ub)
      begin
         sx = a[31];
         sy = b[31] ^ sub;
         ex = ua[39:32];
         d = ua[39:32] - ub[39:32];
         mx = ua[31:0];
         my = ub[31:0];
      end
      else
      begin
         sx = b[31] ^ sub;
         sy = a[31];
         ex = ub[39:32];
         d = ub[39:32] - ua[39:32];
         mx = ub[31:0];
         my = ua[31:0];
      end
      // shifts beyond the width would wrap in some tools, so clamp
      my = (d > 8'h1F) ? 32'h0 : (my >> d);
      if (sx == sy)
         sum = {1'b0, mx} + {1'b0, my};
      else
         sum = {1'b0, mx} - {1'b0, my};
      er = $signed({4'h0, ex});
      if (sum[32])
      begin
         ms = sum[32:1];
         er = er + 12'sh001;
      end
      else
      begin
         z = fau_lzc(sum[31:0]);
         ms = sum[31:0] << z;
         er = er - $signed({6'h00, z});
      end
      result = fau_pack(sx, er, ms);
   end

endmodule // fau_addsub
`default_nettype wire

//--- fau_unit.sv
// float add, subtract and decimal-to-binary convert unit with APB registers
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fau_unit
#(
   parameter int DEPTH = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fau_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic drive_input,
   input wire logic scan_tick,
   output logic busy,
   output logic zero_flag_bit,
   output logic borrow_flag_bit,
   output logic carry_flag_bit,
   output logic irq
);
   import fau_pkg::*;

   localparam int IDX_W = $clog2(DEPTH);

   // software registers
   logic [31:0] ctrl_reg;
   logic [31:0] oper_reg;
   logic [31:0] const1_reg;
   logic [31:0] const2_reg;
   logic [3:0] int_stat_reg;
   logic [3:0] int_mask_reg;
   logic [15:0] data_mem [DEPTH];

   // bus answer
   logic ack_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [31:0] rd_data;
   logic rd_ok;
   logic wr_commit;
   logic [7:0] data_off;
   logic data_hit;
   logic [IDX_W-1:0] data_idx;

   // engine state
   fau_state_type state_reg;
   logic drive_prev_reg;
   logic trig;
   logic [31:0] opa_reg;
   logic [31:0] opb_reg;
   logic sub_reg;
   logic [IDX_W-1:0] dst_reg;
   logic acc_sign_reg;
   logic signed [11:0] acc_exp_reg;
   logic [31:0] acc_man_reg;
   logic signed [15:0] cnt_reg;
   logic [34:0] as_res;
   logic [34:0] wb_val;
   logic wb_en;
   logic [35:0] prod;
   logic [35:0] quot;
   logic [39:0] conv_start;
   logic [3:0] stat_clr;
   logic [3:0] stat_set;

   // operand slots and operation select
   logic [IDX_W-1:0] s1_idx;
   logic [IDX_W-1:0] s2_idx;
   logic [1:0] op_sel;

   // a float lives in two consecutive words, low half first
   function automatic logic [31:0] pair_rd(input logic [IDX_W-1:0] i);
      logic [IDX_W-1:0] j;
      j = IDX_W'(i + 1'b1);
      return {data_mem[j], data_mem[i]};
   endfunction

   assign s1_idx = oper_reg[OPER_S1_LSB +: IDX_W];
   assign s2_idx = oper_reg[OPER_S2_LSB +: IDX_W];
   assign op_sel = ctrl_reg[CTRL_OP_LSB +: 2];

   // data window decode
   assign data_off = paddr - OFS_DATA_BASE;
   assign data_hit = (paddr >= OFS_DATA_BASE) && (int'(data_off[7:2]) < DEPTH);
   assign data_idx = data_off[IDX_W+1:2];

   // read mux and map check
   always_comb
   begin
      rd_data = 32'h0;
      rd_ok = 1'b1;
      case (paddr)
         OFS_CTRL: rd_data = ctrl_reg;
         OFS_OPER: rd_data = oper_reg;
         OFS_CONST1: rd_data = const1_reg;
         OFS_CONST2: rd_data = const2_reg;
         OFS_FLAGS: rd_data = {28'h0, carry_flag_bit, borrow_flag_bit, zero_flag_bit, busy};
         OFS_INT_STAT: rd_data = {28'h0, int_stat_reg};
         OFS_INT_MASK: rd_data = {28'h0, int_mask_reg};
         default:
         begin
            if (data_hit)
               rd_data = {16'h0, data_mem[data_idx]};
            else
               rd_ok = 1'b0;
         end
      endcase
   end

   // one wait state: the first access cycle latches the answer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         if (psel && penable && !ack_reg)
         begin
            ack_reg <= 1'b1;
            prdata_reg <= pwrite ? 32'h0 : rd_data;
            pslverr_reg <= !rd_ok;
         end
         else
            ack_reg <= 1'b0;
      end
   end

   assign pready = psel & penable & ack_reg & clk_en; // a frozen unit must not finish a transfer
   assign prdata = prdata_reg;
   assign pslverr = pready & pslverr_reg;
   // writes land only at the edge that completes the transfer
   assign wr_commit = pready & pwrite & !pslverr_reg & clk_en;

   // control and operand registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= CTRL_RESET;
         oper_reg <= OPER_RESET;
         const1_reg <= CONST_RESET;
         const2_reg <= CONST_RESET;
         int_mask_reg <= MASK_RESET;
      end
      else if (wr_commit)
      begin
         case (paddr)
            OFS_CTRL: ctrl_reg <= pwdata;
            OFS_OPER: oper_reg <= pwdata;
            OFS_CONST1: const1_reg <= pwdata;
            OFS_CONST2: const2_reg <= pwdata;
            OFS_INT_MASK: int_mask_reg <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // drive edge memory for pulse mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         drive_prev_reg <= 1'b0;
      else if (clk_en)
         drive_prev_reg <= drive_input;
   end

   // pulse mode fires on the rising edge, continuous on every scan
   always_comb
   begin
      if (ctrl_reg[CTRL_PULSE_BIT])
         trig = drive_input & !drive_prev_reg;
      else
         trig = drive_input & scan_tick;
   end

   // conversion start: the integer in slot s1 read as a float; constants are not used
   always_comb
   begin
      conv_start = fau_unpack(fau_int_to_float(32'($signed(data_mem[s1_idx]))));
   end

   fau_addsub u_addsub
   (
      .a(opa_reg),
      .b(opb_reg),
      .sub(sub_reg),
      .result(as_res)
   );

   // scale steps; the product has the hidden one at bit 34 or 35, the quotient at bit 31 or 32
   assign prod = {4'h0, acc_man_reg} * TEN;
   assign quot = {acc_man_reg, 4'h0} / TEN;

   // result write-back select
   always_comb
   begin
      wb_en = 1'b0;
      wb_val = as_res;
      if (state_reg == ST_ADD)
         wb_en = 1'b1;
      else if (state_reg == ST_CONV && (cnt_reg == 16'sh0000 || acc_man_reg == 32'h0))
      begin
         wb_en = 1'b1;
         wb_val = fau_pack(acc_sign_reg, acc_exp_reg, acc_man_reg);
      end
   end

   // operation sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         opa_reg <= 32'h0;
         opb_reg <= 32'h0;
         sub_reg <= 1'b0;
         dst_reg <= '0;
         acc_sign_reg <= 1'b0;
         acc_exp_reg <= 12'sh000;
         acc_man_reg <= 32'h0;
         cnt_reg <= 16'sh0000;
      end
      else if (clk_en)
      begin
         case (state_reg)
            ST_IDLE:
            begin
               dst_reg <= oper_reg[OPER_D_LSB +: IDX_W];
               if (trig && (op_sel == OP_ADD || op_sel == OP_SUB))
               begin
                  // same slot may be named twice; both reads see one value
                  opa_reg <= ctrl_reg[CTRL_K1_BIT] ? fau_int_to_float(const1_reg)
                                                   : pair_rd(s1_idx);
                  opb_reg <= ctrl_reg[CTRL_K2_BIT] ? fau_int_to_float(const2_reg)
                                                   : pair_rd(s2_idx);
                  sub_reg <= (op_sel == OP_SUB);
                  state_reg <= ST_ADD;
               end
               else if (trig && op_sel == OP_CONV)
               begin
                  acc_sign_reg <= data_mem[s1_idx][15];
                  acc_exp_reg <= $signed({4'h0, conv_start[39:32]});
                  acc_man_reg <= conv_start[31:0];
                  cnt_reg <= $signed(data_mem[IDX_W'(s1_idx + 1'b1)]);
                  state_reg <= ST_CONV;
               end
            end
            ST_ADD:
               state_reg <= ST_IDLE;
            ST_CONV:
            begin
               // one power of ten per cycle keeps the datapath small
               if (wb_en)
                  state_reg <= ST_IDLE;
               else if (cnt_reg > 16'sh0000)
               begin
                  cnt_reg <= cnt_reg - 16'sh0001;
                  if (prod[35])
                  begin
                     acc_man_reg <= prod[35:4];
                     acc_exp_reg <= acc_exp_reg + 12'sh004;
                  end
                  else
                  begin
                     acc_man_reg <= prod[34:3];
                     acc_exp_reg <= acc_exp_reg + 12'sh003;
                  end
               end
               else
               begin
                  cnt_reg <= cnt_reg + 16'sh0001;
                  if (quot[32])
                  begin
                     acc_man_reg <= quot[32:1];
                     acc_exp_reg <= acc_exp_reg - 12'sh003;
                  end
                  else
                  begin
                     acc_man_reg <= quot[31:0];
                     acc_exp_reg <= acc_exp_reg - 12'sh004;
                  end
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // register file: engine write-back wins over a bus write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < DEPTH; i++)
            data_mem[i] <= 16'h0000;
      end
      else
      begin
         if (wr_commit && data_hit)
            data_mem[data_idx] <= pwdata[15:0];
         if (clk_en && wb_en)
         begin
            data_mem[dst_reg] <= wb_val[15:0];
            data_mem[IDX_W'(dst_reg + 1'b1)] <= wb_val[31:16];
         end
      end
   end

   // result flags follow the last finished operation
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         zero_flag_bit <= 1'b0;
         borrow_flag_bit <= 1'b0;
         carry_flag_bit <= 1'b0;
      end
      else if (clk_en && wb_en)
      begin
         zero_flag_bit <= wb_val[32];
         borrow_flag_bit <= wb_val[33];
         carry_flag_bit <= wb_val[34];
      end
   end

   // sticky events, write one to clear; a new event beats the clear
   assign stat_clr = (wr_commit && paddr == OFS_INT_STAT) ? pwdata[3:0] : 4'h0;
   assign stat_set = (clk_en && wb_en) ? {wb_val[34:32], 1'b1} : 4'h0;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_stat_reg <= 4'h0;
      else
         int_stat_reg <= (int_stat_reg & ~stat_clr) | stat_set;
   end

   assign irq = |(int_stat_reg & int_mask_reg);
   assign busy = (state_reg != ST_IDLE);

endmodule // fau_unit
`default_nettype wire

//--- fau_unit_monitor.sv
// checker of bus handshake, trigger and flag relations at the float unit's ports
`timescale 1ns/10ps
`default_nettype none
module fau_unit_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fau_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic drive_input,
   input wire logic scan_tick,
   input wire logic busy,
   input wire logic zero_flag_bit,
   input wire logic borrow_flag_bit,
   input wire logic carry_flag_bit,
   input wire logic irq
);
   import fau_pkg::*;
   default clocking mon_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // one wait state, then a single-cycle answer inside an access phase
   a_ready_wait: assert property (clk_en && psel && penable && !pready |=> pready || !clk_en)
      else $error("pready missing after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
      else $error("pready outside an access phase");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // flags move only at the edge that ends an operation
   a_flags_hold: assert property (!$past(busy) |->
      $stable({zero_flag_bit, borrow_flag_bit, carry_flag_bit}))
      else $error("result flags changed without an operation");
   a_zero_alone: assert property (zero_flag_bit |-> !borrow_flag_bit && !carry_flag_bit)
      else $error("zero flag raised with borrow or carry");
   a_flag_excl: assert property (!(borrow_flag_bit && carry_flag_bit))
      else $error("borrow and carry both raised");
   // pulse mode needs a fresh rising drive, continuous mode a scan marker
   a_start_cause: assert property ($rose(busy) |-> $past(drive_input) &&
      ($past(scan_tick) || !$past(drive_input, 2)))
      else $error("operation started without a trigger");
   a_busy_bound: assert property ($rose(busy) |-> ##[1:50] !busy)
      else $error("operation did not finish in time");
   a_irq_cause: assert property ($rose(irq) |-> $past(busy) || $past(pready && pwrite))
      else $error("irq rose without an event or a write");
endmodule // fau_unit_monitor

bind fau_unit fau_unit_monitor mon_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_input(drive_input),
   .scan_tick(scan_tick), .busy(busy), .zero_flag_bit(zero_flag_bit),
   .borrow_flag_bit(borrow_flag_bit), .carry_flag_bit(carry_flag_bit), .irq(irq));
`default_nettype wire

//--- fau_engine_model.sv
// model of the instruction engine: drive contact and program scan marker
`timescale 1ns/10ps
`default_nettype none
module fau_engine_model
#(
   parameter int SCAN_PERIOD = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic drive_req,
   output logic drive_input,
   output logic scan_tick
);
   logic [7:0] scan_cnt_reg;

   // drive contact follows the program after one register stage
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         drive_input <= 1'b0;
      else
         drive_input <= drive_req;

   // scan marker runs free, like the program loop, once per scan
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         scan_cnt_reg <= 8'h00;
         scan_tick <= 1'b0;
      end
      else
      begin
         scan_tick <= (scan_cnt_reg == 8'(SCAN_PERIOD - 1));
         scan_cnt_reg <= (scan_cnt_reg == 8'(SCAN_PERIOD - 1)) ? 8'h00 : scan_cnt_reg + 8'h01;
      end
endmodule // fau_engine_model
`default_nettype wire

//--- test_float_add_sub_convert_unit.sv
// self-checking bench of the float unit through its bus and drive inputs
`timescale 1ns/10ps
`default_nettype none
module test_float_add_sub_convert_unit;
   import fau_pkg::*;
   typedef struct packed
   {
      logic [4:0] ctrl;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] k;
      logic [31:0] res;
      logic [2:0] flg;
   } fau_row_type;

   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, pair;
   logic drive_req, drive_input, scan_tick, busy, zero_f, borrow_f, carry_f, irq;
   int fail_count, samples_checked;
   // ctrl, source pair one, source pair two, constant, result, {carry, borrow, zero}
   fau_row_type rows [12] = '{
      '{5'h05, 32'h3F80_0000, 32'h4000_0000, 32'h0, 32'h4040_0000, 3'h0},
      '{5'h06, 32'h3F80_0000, 32'h3F80_0000, 32'h0, 32'h0000_0000, 3'h1},
      '{5'h06, 32'h3F80_0000, 32'h4000_0000, 32'h0, 32'hBF80_0000, 3'h0},
      '{5'h05, 32'h7F7F_FFFF, 32'h7F7F_FFFF, 32'h0, 32'h7F7F_FFFF, 3'h4},
      '{5'h06, 32'h00C0_0000, 32'h0080_0000, 32'h0, 32'h0000_0000, 3'h2},
      '{5'h05, 32'h3F00_0000, 32'hBF80_0000, 32'h0, 32'hBF00_0000, 3'h0},
      '{5'h04, 32'h0000_04D2, 32'h0, 32'h0, 32'h449A_4000, 3'h0},
      '{5'h04, 32'h0001_013A, 32'h0, 32'h0, 32'h4544_4000, 3'h0},
      '{5'h04, 32'h0005_0000, 32'h0, 32'h0, 32'h0000_0000, 3'h1},
      '{5'h04, 32'h0000_FFFB, 32'h0, 32'h0, 32'hC0A0_0000, 3'h0},
      '{5'h0E, 32'h0, 32'h3F80_0000, 32'h0000_04D2, 32'h449A_2000, 3'h0},
      '{5'h15, 32'h4000_0000, 32'h0, 32'hFFFF_FFFD, 32'hBF80_0000, 3'h0}};

   fau_unit #(.DEPTH(16)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_input(drive_input),
      .scan_tick(scan_tick), .busy(busy), .zero_flag_bit(zero_f),
      .borrow_flag_bit(borrow_f), .carry_flag_bit(carry_f), .irq(irq));
   fau_engine_model #(.SCAN_PERIOD(16)) eng_u (.pclk(pclk), .presetn(presetn),
      .drive_req(drive_req), .drive_input(drive_input), .scan_tick(scan_tick));

   task automatic end_of_test;
      if (fail_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk32(input string name, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask

   // one transfer; entered right after a rising edge, answer taken at the edge pready is seen
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // values read here are those the unit samples at this edge
      while (pready !== 1'b1)
      begin
         n++;
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      chk32("pready wait", 32'h1, 32'(n));
   endtask

   task automatic rd_pair(input int idx);
      apb(1'b0, OFS_DATA_BASE + 8'(4 * idx), 32'h0);
      pair[15:0] = rd[15:0];
      apb(1'b0, OFS_DATA_BASE + 8'(4 * idx + 4), 32'h0);
      pair[31:16] = rd[15:0];
   endtask

   // raise the drive contact for a while, then wait for the unit to go idle
   task automatic run_drive(input int hold);
      drive_req <= 1'b1;
      repeat (hold) @(posedge pclk);
      drive_req <= 1'b0;
      // a hang is left to the watchdog
      while (busy !== 1'b0)
         @(posedge pclk);
      repeat (3) @(posedge pclk);
   endtask

   task automatic run_row(input fau_row_type r);
      logic [63:0] ab;
      ab = {r.b, r.a};
      for (int i = 0; i < 4; i++)
         apb(1'b1, OFS_DATA_BASE + 8'(4 * i), {16'h0, ab[16 * i +: 16]});
      apb(1'b1, OFS_CONST1, r.k);
      apb(1'b1, OFS_CONST2, r.k);
      apb(1'b1, OFS_OPER, 32'h0004_0200);
      apb(1'b1, OFS_CTRL, {27'h0, r.ctrl});
      run_drive(60);
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // hang guard of 20000 cycles, far beyond the roughly 1500 the sequence needs
   initial
   begin
      #400000;
      fail_count++;
      end_of_test();
   end

   initial
   begin
      {presetn, psel, penable, pwrite, drive_req, paddr, pwdata} = '0;
      clk_en = 1'b1;
      fail_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk32("idle ports", 32'h0, {27'h0, busy, zero_f, borrow_f, carry_f, irq});
      apb(1'b0, OFS_CTRL, 32'h0);
      chk32("ctrl reset", CTRL_RESET, rd);
      apb(1'b0, OFS_INT_MASK, 32'h0);
      chk32("mask reset", {28'h0, MASK_RESET}, rd);
      // table of arithmetic and conversion cases, including saturation high and flush to zero
      for (int i = 0; i < 12; i++)
      begin
         run_row(rows[i]);
         rd_pair(4);
         chk32("result", rows[i].res, pair);
         apb(1'b0, OFS_FLAGS, 32'h0);
         chk32("flags reg", {28'h0, rows[i].flg, 1'b0}, rd);
         chk32("flag ports", {29'h0, rows[i].flg}, {29'h0, carry_f, borrow_f, zero_f});
      end
      chk32("irq masked", 32'h0, {31'h0, irq});
      // pulse mode with one register as both sources and destination runs once
      apb(1'b1, OFS_DATA_BASE + 8'h18, 32'h0);
      apb(1'b1, OFS_DATA_BASE + 8'h1C, 32'h3F80);
      apb(1'b1, OFS_OPER, 32'h0006_0606);
      apb(1'b1, OFS_CTRL, 32'h5);
      run_drive(60);
      rd_pair(6);
      chk32("pulse once", 32'h4000_0000, pair);
      // continuous mode doubles the register on each of three scans
      apb(1'b1, OFS_CTRL, 32'h1);
      drive_req <= 1'b1;
      @(posedge pclk); // contact reaches the unit one cycle late, so count scans after it
      repeat (3)
      begin
         @(posedge pclk);
         while (scan_tick !== 1'b1)
            @(posedge pclk);
      end
      run_drive(1);
      rd_pair(6);
      chk32("per scan", 32'h4180_0000, pair);
      // clock enable low freezes the engine while drive and scans go on
      clk_en <= 1'b0;
      drive_req <= 1'b1;
      repeat (40) @(posedge pclk);
      chk32("frozen busy", 32'h0, {31'h0, busy});
      drive_req <= 1'b0;
      repeat (3) @(posedge pclk);
      clk_en <= 1'b1;
      rd_pair(6);
      chk32("frozen pair", 32'h4180_0000, pair);
      // unmapped place is refused on the bus
      apb(1'b0, 8'h30, 32'h0);
      chk32("slave error", 32'h1, {31'h0, err});
      // done is pending: unmask raises irq, write-one clears it
      apb(1'b1, OFS_INT_MASK, 32'h1);
      chk32("irq raised", 32'h1, {31'h0, irq});
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk32("status sticky", 32'hF, rd);
      apb(1'b1, OFS_INT_STAT, 32'hF);
      chk32("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk32("status clear", 32'h0, rd);
      end_of_test();
   end
endmodule // test_float_add_sub_convert_unit
`default_nettype wire
